// ==== inc/sfs_map.vh ====
`ifndef SFS_MAP_VH
`define SFS_MAP_VH

// ----------------------------------------
// fault codes
// ----------------------------------------
`define SFS_CODE_NONE 8'h00
`define SFS_CODE_HWLIM 8'h12
`define SFS_CODE_UNDERV 8'h14
`define SFS_CODE_OVERV 8'h15
`define SFS_CODE_STALL 8'h16
`define SFS_CODE_TRACK 8'h17
`define SFS_CODE_I2T 8'h1E
`define SFS_CODE_BRAKE 8'h28

// ----------------------------------------
// response classes
// ----------------------------------------
`define SFS_RESP_NONE 2'h0
`define SFS_RESP_MAXTRQ 2'h1
`define SFS_RESP_RAMP 2'h2
`define SFS_RESP_DISABLE 2'h3

// ----------------------------------------
// reset defaults, volts in 0.1 V steps
// ----------------------------------------
`define SFS_UMIN_DEF 16'h0064
`define SFS_UMAX_DEF 16'h0258

`endif

// ==== rtl/sfs_timer.v ====
`timescale 1ns/10ps
// counts consecutive cycles of a condition, flags when limit reached
module sfs_timer #(
    parameter W = 24
) (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // count control
    input wire run,
    input wire [W-1:0] limit,
    output reg expired
);

reg [W-1:0] cnt_r;

always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        cnt_r <= {W{1'b0}};
        expired <= 1'b0;
    end else if (!run) begin
        cnt_r <= {W{1'b0}};
        expired <= 1'b0;
    end else begin
        // saturate so a held condition stays expired
        if (cnt_r != limit) begin
            cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
        end
        expired <= (cnt_r == limit) || (cnt_r + {{(W-1){1'b0}}, 1'b1} == limit);
    end
end

endmodule

// ==== rtl/sfs_supervisor.v ====
`timescale 1ns/10ps
`include "sfs_map.vh"

module sfs_supervisor #(
    parameter VW = 16,
    parameter TW = 24,
    parameter EW = 16,
    parameter PW = 24
) (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // limit switches and travel range
    input wire limit_pos,
    input wire limit_neg,
    input wire in_travel,
    // dc link
    input wire [VW-1:0] dclink_volt,
    input wire [VW-1:0] dclink_min,
    input wire [VW-1:0] dclink_max,
    input wire volt_cfg_use,
    // stall
    input wire ctrl_enabled,
    input wire speed_above_zero,
    input wire [TW-1:0] block_time,
    // tracking error
    input wire [EW-1:0] track_err,
    input wire [EW-1:0] track_limit,
    input wire [TW-1:0] track_window,
    // thermal load
    input wire [PW-1:0] motor_loss_avg,
    input wire [PW-1:0] motor_loss_max,
    // brake switch
    input wire brake_overload,
    // acknowledge
    input wire fault_ack,
    // status and response
    output reg [7:0] fault_code,
    output reg fault_active,
    output reg stop_max_torque,
    output reg stop_ramp,
    output reg ctrl_disable,
    output reg power_disable
);

// ----------------------------------------
// threshold compare
// ----------------------------------------
wire [VW-1:0] umin = volt_cfg_use ? dclink_min : `SFS_UMIN_DEF;
wire [VW-1:0] umax = volt_cfg_use ? dclink_max : `SFS_UMAX_DEF;
wire under_v = dclink_volt < umin;
wire over_v = dclink_volt > umax;
wire track_hi = track_err > track_limit;
wire thermal = motor_loss_avg > motor_loss_max;

// ----------------------------------------
// timed monitors
// ----------------------------------------
wire stall_exp;
wire track_exp;

sfs_timer #(.W(TW)) u_stall (
    .clk(clk),
    .rst_n(rst_n),
    .run(ctrl_enabled && !speed_above_zero),
    .limit(block_time),
    .expired(stall_exp)
);

sfs_timer #(.W(TW)) u_track (
    .clk(clk),
    .rst_n(rst_n),
    .run(track_hi),
    .limit(track_window),
    .expired(track_exp)
);

// ----------------------------------------
// limit switch arming
// ----------------------------------------
// disarmed after a trip so the axis can drive back out of the switch
reg lim_armed_r;
wire lim_hit = lim_armed_r && (limit_pos || limit_neg);

always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        lim_armed_r <= 1'b1;
    end else if (lim_hit) begin
        lim_armed_r <= 1'b0;
    end else if (in_travel && !limit_pos && !limit_neg) begin
        lim_armed_r <= 1'b1;
    end
end

// ----------------------------------------
// fault selection, harshest response first
// ----------------------------------------
reg [7:0] code_nxt;
reg [1:0] resp_nxt;
reg hit_nxt;

always @* begin
    code_nxt = `SFS_CODE_NONE;
    resp_nxt = `SFS_RESP_NONE;
    hit_nxt = 1'b1;
    if (thermal) begin
        code_nxt = `SFS_CODE_I2T;
        resp_nxt = `SFS_RESP_DISABLE;
    end else if (stall_exp) begin
        code_nxt = `SFS_CODE_STALL;
        resp_nxt = `SFS_RESP_DISABLE;
    end else if (lim_hit) begin
        code_nxt = `SFS_CODE_HWLIM;
        resp_nxt = `SFS_RESP_MAXTRQ;
    end else if (under_v) begin
        code_nxt = `SFS_CODE_UNDERV;
        resp_nxt = `SFS_RESP_RAMP;
    end else if (over_v) begin
        code_nxt = `SFS_CODE_OVERV;
        resp_nxt = `SFS_RESP_RAMP;
    end else if (track_exp) begin
        code_nxt = `SFS_CODE_TRACK;
        resp_nxt = `SFS_RESP_RAMP;
    end else if (brake_overload) begin
        code_nxt = `SFS_CODE_BRAKE;
        resp_nxt = `SFS_RESP_RAMP;
    end else begin
        hit_nxt = 1'b0;
    end
end

// ----------------------------------------
// response decode
// ----------------------------------------
// stall and thermal share the disable class but act on different stages
wire maxtrq_nxt = (resp_nxt == `SFS_RESP_MAXTRQ);
wire ramp_nxt = (resp_nxt == `SFS_RESP_RAMP);
wire ctrl_off_nxt = (resp_nxt == `SFS_RESP_DISABLE) && (code_nxt == `SFS_CODE_STALL);
wire power_off_nxt = (resp_nxt == `SFS_RESP_DISABLE) && (code_nxt == `SFS_CODE_I2T);

// ----------------------------------------
// latch state
// ----------------------------------------
// one-hot: clear, or holding a code until the application acknowledges
localparam ST_CLEAR = 2'b01;
localparam ST_HELD = 2'b10;

reg [1:0] state_r;
reg [1:0] state_nxt;
reg load_nxt;
reg drop_nxt;

always @* begin
    state_nxt = state_r;
    load_nxt = 1'b0;
    drop_nxt = 1'b0;
    case (state_r)
        ST_CLEAR: begin
            if (hit_nxt) begin
                state_nxt = ST_HELD;
                load_nxt = 1'b1;
            end
        end
        ST_HELD: begin
            // a cause still present at the ack reloads, so no fault is lost
            if (fault_ack && hit_nxt) begin
                load_nxt = 1'b1;
            end else if (fault_ack) begin
                state_nxt = ST_CLEAR;
                drop_nxt = 1'b1;
            end
        end
        default: begin
            // illegal code: fall back to clear and drop any response
            state_nxt = ST_CLEAR;
            drop_nxt = 1'b1;
        end
    endcase
end

always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        state_r <= ST_CLEAR;
    end else begin
        state_r <= state_nxt;
    end
end

// ----------------------------------------
// latch and acknowledge
// ----------------------------------------
// first fault wins; a new fault in the ack cycle is kept, not lost
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        fault_code <= `SFS_CODE_NONE;
        fault_active <= 1'b0;
        stop_max_torque <= 1'b0;
        stop_ramp <= 1'b0;
        ctrl_disable <= 1'b0;
        power_disable <= 1'b0;
    end else if (load_nxt) begin
        fault_code <= code_nxt;
        fault_active <= 1'b1;
        stop_max_torque <= maxtrq_nxt;
        stop_ramp <= ramp_nxt;
        ctrl_disable <= ctrl_off_nxt;
        power_disable <= power_off_nxt;
    end else if (drop_nxt) begin
        fault_code <= `SFS_CODE_NONE;
        fault_active <= 1'b0;
        stop_max_torque <= 1'b0;
        stop_ramp <= 1'b0;
        ctrl_disable <= 1'b0;
        power_disable <= 1'b0;
    end
end

endmodule

// ==== testbench/sfs_ack_model.sv ====
`timescale 1ns/10ps
module sfs_ack_model (
    input wire clk, input wire rst_n, input wire fault_active, input wire cause_gone,
    output reg fault_ack
);
// acknowledge only once the cause is gone, else set would win and reload the code
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) fault_ack <= 1'h0;
    else fault_ack <= fault_active && cause_gone && !fault_ack;
end
endmodule

// ==== testbench/sfs_properties.sv ====
`timescale 1ns/10ps
module sfs_props (
    input wire clk, input wire rst_n, input wire fault_ack, input wire [7:0] fault_code,
    input wire fault_active, input wire stop_max_torque, input wire stop_ramp,
    input wire ctrl_disable, input wire power_disable, input wire brake_overload,
    input wire [23:0] motor_loss_avg, input wire [23:0] motor_loss_max
);
default clocking @(posedge clk); endclocking
default disable iff (!rst_n);
chk_lim_stop: assert property (fault_code == 8'h12 |-> stop_max_torque) else $error("lim");
chk_volt_ramp: assert property (fault_code inside {8'h14, 8'h15} |-> stop_ramp)
    else $error("volt");
chk_stall_off: assert property (fault_code == 8'h16 |-> ctrl_disable && !power_disable)
    else $error("stall");
chk_track_ramp: assert property (fault_code == 8'h17 |-> stop_ramp) else $error("track");
chk_heat_off: assert property (fault_code == 8'h1E |-> power_disable) else $error("heat");
chk_brake_ramp: assert property (fault_code == 8'h28 |-> stop_ramp) else $error("brake");
chk_code_hold: assert property (fault_active && !fault_ack |=> $stable(fault_code))
    else $error("hold");
wire hot = motor_loss_avg > motor_loss_max;
chk_idle_quiet: assert property (!fault_active |-> fault_code == 8'h00 && !stop_ramp
    && !stop_max_torque && !ctrl_disable && !power_disable) else $error("idle");
chk_brake_latch: assert property (brake_overload && !fault_active |=> fault_active)
    else $error("brake latch");
chk_heat_first: assert property (hot && (!fault_active || fault_ack) |=> power_disable)
    else $error("heat first");
endmodule

// ==== testbench/sfs_supervisor_tb.sv ====
`timescale 1ns/10ps
module sfs_supervisor_tb;
reg clk, rst_n, lp, ln, it, ce, sp, g, vu, bo;
reg [15:0] dv, dn, dx, te, tl;
reg [23:0] bt, tw, la, lm;
wire [7:0] fc;
wire fa, sm, sr, cd, pd, ak;
integer n_fail, n_tests, i;
sfs_supervisor dut (.clk(clk), .rst_n(rst_n), .limit_pos(lp), .limit_neg(ln), .in_travel(it),
    .dclink_volt(dv), .dclink_min(dn), .dclink_max(dx), .volt_cfg_use(vu), .ctrl_enabled(ce),
    .speed_above_zero(sp), .block_time(bt), .track_err(te), .track_limit(tl), .track_window(tw),
    .motor_loss_avg(la), .motor_loss_max(lm), .brake_overload(bo), .fault_ack(ak),
    .fault_code(fc), .fault_active(fa), .stop_max_torque(sm), .stop_ramp(sr),
    .ctrl_disable(cd), .power_disable(pd));
sfs_ack_model ctl (.clk(clk), .rst_n(rst_n), .fault_active(fa), .cause_gone(g), .fault_ack(ak));
initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
end
task stop_test;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
endtask
// ----------------------------------------
// checks
// ----------------------------------------
// wait at most n falling edges for the flag, then code and the four response outputs together
task got(input [7:0] c, input [3:0] r, input e, input integer n);
    for (i = 0; i < n && fa !== e; i = i + 1) @(negedge clk);
    n_tests = n_tests + 1;
    if (fa !== e) begin
        n_fail = n_fail + 1;
        $display("CHECK FAILED fault_active expected %b seen %b", e, fa);
        stop_test;
    end else if ({c, r} !== {fc, sm, sr, cd, pd}) begin
        n_fail = n_fail + 1;
        $display("CHECK FAILED code_response expected %h seen %h", {c, r}, {fc, sm, sr, cd, pd});
    end
endtask
// ack lands one edge after the cause is gone, the clear one edge later
task clr;
    g = 1'h1;
    got(8'h00, 4'h0, 1'h0, 2);
    g = 1'h0;
endtask
task t_lim;
    lp = 1'h1;
    got(8'h12, 4'h8, 1'h1, 1);
    {lp, it} = 2'h0;
    clr;
    ln = 1'h1;
    repeat (4) @(negedge clk);
    got(8'h00, 4'h0, 1'h0, 0);
    {ln, it} = 2'h1;
    @(negedge clk);
    lp = 1'h1;
    got(8'h12, 4'h8, 1'h1, 1);
    lp = 1'h0;
    clr;
    $display("t_lim done");
endtask
task t_volt;
    dv = 16'h0064;
    repeat (2) @(negedge clk);
    got(8'h00, 4'h0, 1'h0, 0);
    dv = 16'h0063;
    got(8'h14, 4'h4, 1'h1, 1);
    dv = 16'h0258;
    clr;
    repeat (2) @(negedge clk);
    got(8'h00, 4'h0, 1'h0, 0);
    dv = 16'h0259;
    got(8'h15, 4'h4, 1'h1, 1);
    dv = 16'h012C;
    clr;
    vu = 1'h1;
    dn = 16'h00C8;
    dx = 16'h01F4;
    dv = 16'h01F5;
    got(8'h15, 4'h4, 1'h1, 1);
    dv = 16'h00C7;
    repeat (2) @(negedge clk);
    got(8'h15, 4'h4, 1'h1, 0);
    dv = 16'h012C;
    clr;
    dv = 16'h00C7;
    got(8'h14, 4'h4, 1'h1, 1);
    {vu, dv} = 17'h0012C;
    clr;
    $display("t_volt done");
endtask
task t_stall;
    {ce, sp} = 2'h3;
    repeat (30) @(negedge clk);
    got(8'h00, 4'h0, 1'h0, 0);
    sp = 1'h0;
    repeat (20) @(negedge clk);
    got(8'h00, 4'h0, 1'h0, 0);
    got(8'h16, 4'h2, 1'h1, 1);
    ce = 1'h0;
    clr;
    $display("t_stall done");
endtask
task t_track;
    te = 16'h0080;
    repeat (12) @(negedge clk);
    got(8'h00, 4'h0, 1'h0, 0);
    te = 16'h0081;
    repeat (8) @(negedge clk);
    te = 16'h0000;
    @(negedge clk);
    te = 16'h0081;
    repeat (10) @(negedge clk);
    got(8'h00, 4'h0, 1'h0, 0);
    got(8'h17, 4'h4, 1'h1, 1);
    te = 16'h0000;
    clr;
    $display("t_track done");
endtask
task t_heat;
    la = 24'h000400;
    repeat (2) @(negedge clk);
    got(8'h00, 4'h0, 1'h0, 0);
    la = 24'h000401;
    got(8'h1E, 4'h1, 1'h1, 1);
    la = 24'h000000;
    clr;
    $display("t_heat done");
endtask
task t_brake;
    bo = 1'h1;
    got(8'h28, 4'h4, 1'h1, 1);
    la = 24'h000401;
    repeat (3) @(negedge clk);
    got(8'h28, 4'h4, 1'h1, 0);
    {bo, g} = 2'h1;
    repeat (2) @(negedge clk);
    got(8'h1E, 4'h1, 1'h1, 0);
    la = 24'h000000;
    got(8'h00, 4'h0, 1'h0, 2);
    g = 1'h0;
    $display("t_brake done");
endtask
task t_reset;
    lp = 1'h1;
    got(8'h12, 4'h8, 1'h1, 1);
    {lp, it} = 2'h0;
    @(negedge clk);
    rst_n = 1'h0;
    #1;
    got(8'h00, 4'h0, 1'h0, 0);
    repeat (3) @(negedge clk);
    rst_n = 1'h1;
    @(negedge clk);
    lp = 1'h1;
    got(8'h12, 4'h8, 1'h1, 1);
    {lp, it} = 2'h1;
    clr;
    $display("t_reset done");
endtask
initial begin
    {rst_n, lp, ln, ce, sp, g, vu, bo, it} = 9'h001;
    {dv, dn, dx, te, tl} = 80'h012C_0064_0258_0000_0080;
    {bt, tw, la, lm} = 96'h000014_00000A_000000_000400;
    n_fail = 0;
    n_tests = 0;
    repeat (3) @(negedge clk);
    rst_n = 1'h1;
    @(negedge clk);
    got(8'h00, 4'h0, 1'h0, 0);
    t_lim;
    t_volt;
    t_stall;
    t_track;
    t_heat;
    t_brake;
    t_reset;
    stop_test;
end
endmodule
bind sfs_supervisor sfs_props chk_u (.clk(clk), .rst_n(rst_n), .fault_ack(fault_ack),
    .fault_code(fault_code), .fault_active(fault_active), .stop_max_torque(stop_max_torque),
    .stop_ramp(stop_ramp), .ctrl_disable(ctrl_disable), .power_disable(power_disable),
    .brake_overload(brake_overload), .motor_loss_avg(motor_loss_avg),
    .motor_loss_max(motor_loss_max));
